/* src/qbs_pkg.sv */
// ==========================================================================
// Shared constants of the burst-of-four SRAM link.
// ==========================================================================
package qbs_pkg;

  localparam int ADDR_W       = 20;
  localparam int DATA_W       = 18;
  localparam int LANES        = 2;
  localparam int LANE_W       = 9;
  localparam int LANE_LOW     = 0;
  localparam int LANE_HIGH    = 1;
  localparam int BEATS        = 4;
  localparam int BEAT_W       = 2;
  // Latencies are counted in half cycles of the true clock, one system clock each.
  localparam int RD_LAT_HALF  = 5;
  localparam int WR_LAT_HALF  = 2;
  localparam int WBUF_ENTRIES = 2;
  localparam int FIFO_DEPTH   = 32;
  localparam int WORD_W       = DATA_W + LANES;

  typedef enum logic {
    ENG_IDLE,
    ENG_BURST
  } qbs_eng_e;

endpackage

/* src/qbs_link_if.sv */
`timescale 1ns/100ps
// ==========================================================================
// Link between the memory controller and the SRAM device.
// ==========================================================================
interface qbs_link_if
  import qbs_pkg::*;
#(
  parameter int AW = ADDR_W
) ();

  logic              k_run;
  logic              k_true;
  logic              rd_sel_n;
  logic              wr_sel_n;
  logic [AW-1:0]     addr;
  logic [DATA_W-1:0] d;
  logic              lane_low_write_enable_n;
  logic              lane_high_write_enable_n;
  logic [DATA_W-1:0] q;
  logic              q_oe;

  modport dev (
    input  k_run,
    input  k_true,
    input  rd_sel_n,
    input  wr_sel_n,
    input  addr,
    input  d,
    input  lane_low_write_enable_n,
    input  lane_high_write_enable_n,
    output q,
    output q_oe
  );

  modport ctl (
    output k_run,
    output k_true,
    output rd_sel_n,
    output wr_sel_n,
    output addr,
    output d,
    output lane_low_write_enable_n,
    output lane_high_write_enable_n,
    input  q,
    input  q_oe
  );

endinterface

/* src/qbs_sram_dev.sv */
`timescale 1ns/100ps
// How it works
// - Burst addresses run start, plus one, two, three.
// - Read strobe low on true edge selects read.
// - Write strobe low on true edge selects write.
// - Read and write engines run concurrently.
// - Commands captured only on true clock edges.
// - Controller finishes all bursts before stopping clocks.
// - Read beats leave at 2.5 to 4.0 cycles.
// - Write beats captured at 1.0 to 2.5 cycles.
// - Same-type command on next true edge ignored.
// - Both strobes low: accepted read wins, write dropped.
// - Two lane enables gate each beat's halves.
// - Controller drives lane enables only for issued writes.
// - Lane enables apply per beat independently.
// - Last two writes buffered and forwarded to reads.
module qbs_sram_dev
  import qbs_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  qbs_link_if.dev   link,
  output logic      read_busy,
  output logic      write_busy
);

  logic                   run;
  logic                   rd_cmd;
  logic                   wr_cmd;
  logic                   rd_acc;
  logic                   wr_acc;
  logic                   launch;
  logic                   start_cap;
  logic                   push;
  logic                   rd_prev_r;
  logic                   wr_prev_r;
  logic [RD_LAT_HALF-1:0] rd_v_sr_r;
  logic [AW-1:0]          rd_a_sr_r [RD_LAT_HALF];
  logic [WR_LAT_HALF-1:0] wr_v_sr_r;
  logic [AW-1:0]          wr_a_sr_r [WR_LAT_HALF];
  qbs_eng_e               rd_state_r;
  qbs_eng_e               wr_state_r;
  logic [AW-1:0]          rb_addr_r;
  logic [BEAT_W-1:0]      rb_cnt_r;
  logic [AW-1:0]          wc_addr_r;
  logic [BEAT_W-1:0]      wc_cnt_r;
  logic [AW-1:0]          look_addr;
  logic [DATA_W-1:0]      look_data;
  logic [LANES-1:0]       lane_en;
  logic [DATA_W-1:0]      wc_d_r [BEATS];
  logic [LANES-1:0]       wc_m_r [BEATS];
  logic [WBUF_ENTRIES-1:0] wb_v_r;
  logic [AW-1:0]          wb_a_r [WBUF_ENTRIES];
  logic [DATA_W-1:0]      wb_d_r [WBUF_ENTRIES][BEATS];
  logic [LANES-1:0]       wb_m_r [WBUF_ENTRIES][BEATS];
  logic [DATA_W-1:0]      mem_r  [2**AW];

  // ========================================================================
  // Command sampling
  // ========================================================================
  assign run       = ce & link.k_run;
  assign rd_cmd    = run & link.k_true & ~link.rd_sel_n;
  assign wr_cmd    = run & link.k_true & ~link.wr_sel_n;
  assign rd_acc    = rd_cmd & ~rd_prev_r;
  assign wr_acc    = wr_cmd & ~wr_prev_r & ~rd_acc;
  assign launch    = rd_v_sr_r[RD_LAT_HALF-1];
  assign start_cap = wr_v_sr_r[WR_LAT_HALF-1];
  assign push      = run & (wr_state_r == ENG_BURST) & (wc_cnt_r == BEAT_W'(BEATS - 1));

  always_comb begin
    lane_en            = '0;
    lane_en[LANE_LOW]  = ~link.lane_low_write_enable_n;
    lane_en[LANE_HIGH] = ~link.lane_high_write_enable_n;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end else if (run && link.k_true) begin
      rd_prev_r <= rd_acc;
      wr_prev_r <= wr_acc;
    end
  end

  // ========================================================================
  // Latency pipes, one stage per half cycle
  // ========================================================================
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_v_sr_r <= '0;
      wr_v_sr_r <= '0;
    end else if (run) begin
      rd_v_sr_r <= {rd_v_sr_r[RD_LAT_HALF-2:0], rd_acc};
      wr_v_sr_r <= {wr_v_sr_r[WR_LAT_HALF-2:0], wr_acc};
    end
  end

  always_ff @(posedge clock) begin
    if (run) begin
      rd_a_sr_r[0] <= link.addr;
      wr_a_sr_r[0] <= link.addr;
      for (int i = 1; i < RD_LAT_HALF; i++) begin
        rd_a_sr_r[i] <= rd_a_sr_r[i-1];
      end
      for (int i = 1; i < WR_LAT_HALF; i++) begin
        wr_a_sr_r[i] <= wr_a_sr_r[i-1];
      end
    end
  end

  // ========================================================================
  // Read path with forwarding from the write buffer
  // ========================================================================
  always_comb begin
    look_addr = launch ? rd_a_sr_r[RD_LAT_HALF-1] : rb_addr_r + AW'(rb_cnt_r);
  end

  // Older entries are applied first so that the newest write wins per lane.
  always_comb begin
    look_data = mem_r[look_addr];
    for (int e = WBUF_ENTRIES - 1; e >= 0; e--) begin
      for (int j = 0; j < BEATS; j++) begin
        if (wb_v_r[e] && ((wb_a_r[e] + AW'(j)) == look_addr)) begin
          for (int l = 0; l < LANES; l++) begin
            if (wb_m_r[e][j][l]) begin
              look_data[l*LANE_W +: LANE_W] = wb_d_r[e][j][l*LANE_W +: LANE_W];
            end
          end
        end
      end
    end
  end

  // The read engine is independent of the write engine.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_state_r <= ENG_IDLE;
      rb_addr_r  <= '0;
      rb_cnt_r   <= '0;
      link.q     <= '0;
      link.q_oe  <= 1'b0;
      read_busy  <= 1'b0;
    end else if (run) begin
      read_busy <= (|rd_v_sr_r) | (rd_state_r == ENG_BURST);
      case (rd_state_r)
        ENG_IDLE: begin
          if (launch) begin
            link.q     <= look_data;
            link.q_oe  <= 1'b1;
            rb_addr_r  <= look_addr;
            rb_cnt_r   <= BEAT_W'(1);
            rd_state_r <= ENG_BURST;
          end else begin
            link.q_oe <= 1'b0;
          end
        end
        ENG_BURST: begin
          link.q    <= look_data;
          link.q_oe <= 1'b1;
          rb_cnt_r  <= rb_cnt_r + BEAT_W'(1);
          if (rb_cnt_r == BEAT_W'(BEATS - 1)) begin
            rd_state_r <= ENG_IDLE;
          end
        end
        default: begin
          rd_state_r <= ENG_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Write capture engine and write buffer
  // ========================================================================
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_state_r <= ENG_IDLE;
      wc_cnt_r   <= '0;
      wb_v_r     <= '0;
      write_busy <= 1'b0;
    end else if (run) begin
      write_busy <= (|wr_v_sr_r) | (wr_state_r == ENG_BURST);
      case (wr_state_r)
        ENG_IDLE: begin
          if (start_cap) begin
            wc_cnt_r   <= BEAT_W'(1);
            wr_state_r <= ENG_BURST;
          end
        end
        ENG_BURST: begin
          wc_cnt_r <= wc_cnt_r + BEAT_W'(1);
          if (push) begin
            wb_v_r     <= {wb_v_r[WBUF_ENTRIES-2:0], 1'b1};
            wr_state_r <= ENG_IDLE;
          end
        end
        default: begin
          wr_state_r <= ENG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (run) begin
      if (wr_state_r == ENG_IDLE && start_cap) begin
        wc_addr_r <= wr_a_sr_r[WR_LAT_HALF-1];
        wc_d_r[0] <= link.d;
        wc_m_r[0] <= lane_en;
      end else if (wr_state_r == ENG_BURST) begin
        wc_d_r[wc_cnt_r] <= link.d;
        wc_m_r[wc_cnt_r] <= lane_en;
      end
      if (push) begin
        for (int e = WBUF_ENTRIES - 1; e > 0; e--) begin
          wb_a_r[e] <= wb_a_r[e-1];
          for (int j = 0; j < BEATS; j++) begin
            wb_d_r[e][j] <= wb_d_r[e-1][j];
            wb_m_r[e][j] <= wb_m_r[e-1][j];
          end
        end
        wb_a_r[0] <= wc_addr_r;
        for (int j = 0; j < BEATS; j++) begin
          wb_d_r[0][j] <= (j == BEATS - 1) ? link.d : wc_d_r[j];
          wb_m_r[0][j] <= (j == BEATS - 1) ? lane_en : wc_m_r[j];
        end
      end
    end
  end

  // A third write pushes the oldest buffered burst into the array.
  always_ff @(posedge clock) begin
    if (run && push && wb_v_r[WBUF_ENTRIES-1]) begin
      for (int j = 0; j < BEATS; j++) begin
        for (int l = 0; l < LANES; l++) begin
          if (wb_m_r[WBUF_ENTRIES-1][j][l]) begin
            mem_r[wb_a_r[WBUF_ENTRIES-1] + AW'(j)][l*LANE_W +: LANE_W] <=
              wb_d_r[WBUF_ENTRIES-1][j][l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

endmodule

/* src/qbs_sram_ctl.sv */
`timescale 1ns/100ps
// ==========================================================================
// Write data FIFO.
// ==========================================================================
module qbs_fifo
  import qbs_pkg::*;
#(
  parameter int W     = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  buf_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          push;
  logic          pop;

  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;
  assign out_valid = (count_r != '0);
  assign out_data  = buf_r[rp_r];
  assign count     = count_r;
  assign count_nxt = count_r + CW'(push) - CW'(pop);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wp_r     <= '0;
      rp_r     <= '0;
      count_r  <= '0;
      in_ready <= 1'b1;
    end else if (ce) begin
      if (push) begin
        wp_r <= wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + PW'(1);
      end
      count_r  <= count_nxt;
      in_ready <= (count_nxt != CW'(DEPTH));
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      buf_r[wp_r] <= in_data;
    end
  end

endmodule

// ==========================================================================
// Memory controller end of the link.
// ==========================================================================
module qbs_sram_ctl
  import qbs_pkg::*;
#(
  parameter int AW     = ADDR_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              ce,
  qbs_link_if.ctl                link,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [AW-1:0]     cmd_addr,
  output logic                   cmd_accept,
  input  wire logic              wd_valid,
  input  wire logic [DATA_W-1:0] wd_data,
  input  wire logic [LANES-1:0]  wd_lanes_n,
  output logic                   wd_ready,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  input  wire logic              stop_req,
  output logic                   clocks_stopped
);

  localparam int CW      = $clog2(FIFO_D + 1);
  localparam int RD_SR_N = RD_LAT_HALF + BEATS + 1;
  localparam int WR_SR_N = WR_LAT_HALF + BEATS;

  logic               f_valid;
  logic [WORD_W-1:0]  f_data;
  logic [CW-1:0]      f_count;
  logic               f_pop;
  logic [RD_SR_N-1:0] rd_sr_r;
  logic [WR_SR_N-1:0] wr_sr_r;
  logic [CW-1:0]      pend_r;
  logic               last_rd_r;
  logic               last_wr_r;
  logic               slot_edge;
  logic               issue_rd;
  logic               issue_wr;
  logic               idle;
  logic               drive_beat;
  logic               cap_beat;
  logic               run_nxt;

  qbs_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_D)
  ) u_wfifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (wd_valid),
    .in_ready  (wd_ready),
    .in_data   ({wd_lanes_n, wd_data}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data),
    .count     (f_count)
  );

  // A command goes out on the edge that opens a true-clock slot.
  assign slot_edge  = ce & link.k_run & ~link.k_true;
  assign issue_rd   = slot_edge & ~stop_req & cmd_valid & ~cmd_write & ~last_rd_r;
  assign issue_wr   = slot_edge & ~stop_req & cmd_valid & cmd_write & ~last_wr_r
                      & (f_count >= pend_r + CW'(BEATS));
  assign idle       = ~(|rd_sr_r) & ~(|wr_sr_r);
  assign drive_beat = ce & link.k_run & f_valid
                      & (|wr_sr_r[WR_LAT_HALF+BEATS-2:WR_LAT_HALF-1]);
  assign cap_beat   = |rd_sr_r[RD_LAT_HALF+BEATS:RD_LAT_HALF+1];
  assign f_pop      = drive_beat;

  always_comb begin
    run_nxt = link.k_run ? ~(stop_req & idle) : ~stop_req;
  end

  // ========================================================================
  // Clock run and phase
  // ========================================================================
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link.k_run     <= 1'b1;
      link.k_true    <= 1'b0;
      clocks_stopped <= 1'b0;
    end else if (ce) begin
      link.k_run     <= run_nxt;
      clocks_stopped <= ~run_nxt;
      if (link.k_run) begin
        link.k_true <= ~link.k_true;
      end
    end
  end

  // ========================================================================
  // Command issue and burst tracking
  // ========================================================================
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link.rd_sel_n <= 1'b1;
      link.wr_sel_n <= 1'b1;
      link.addr     <= '0;
      cmd_accept    <= 1'b0;
      last_rd_r     <= 1'b0;
      last_wr_r     <= 1'b0;
      rd_sr_r       <= '0;
      wr_sr_r       <= '0;
      pend_r        <= '0;
    end else if (ce) begin
      link.rd_sel_n <= ~issue_rd;
      link.wr_sel_n <= ~issue_wr;
      cmd_accept    <= issue_rd | issue_wr;
      if (issue_rd || issue_wr) begin
        link.addr <= cmd_addr;
      end
      if (slot_edge) begin
        last_rd_r <= issue_rd;
        last_wr_r <= issue_wr;
      end
      if (link.k_run) begin
        rd_sr_r <= {rd_sr_r[RD_SR_N-2:0], issue_rd};
        wr_sr_r <= {wr_sr_r[WR_SR_N-2:0], issue_wr};
      end
      pend_r <= pend_r + (issue_wr ? CW'(BEATS) : CW'(0)) - CW'(f_pop);
    end
  end

  // ========================================================================
  // Write beats and read capture
  // ========================================================================
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link.d                        <= '0;
      link.lane_low_write_enable_n  <= 1'b1;
      link.lane_high_write_enable_n <= 1'b1;
    end else if (ce) begin
      if (drive_beat) begin
        link.d                        <= f_data[DATA_W-1:0];
        link.lane_low_write_enable_n  <= f_data[DATA_W+LANE_LOW];
        link.lane_high_write_enable_n <= f_data[DATA_W+LANE_HIGH];
      end else begin
        link.lane_low_write_enable_n  <= 1'b1;
        link.lane_high_write_enable_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (ce) begin
      rd_valid <= link.k_run & cap_beat;
      if (link.k_run && cap_beat) begin
        rd_data <= link.q;
      end
    end
  end

endmodule

/* verification/qbs_link_assertions.sv */
`timescale 1ns/100ps
// ==========================================================================
// Protocol checks on the link between the two ends.
// ==========================================================================
module qbs_link_assertions
  import qbs_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              k_run,
  input wire logic              k_true,
  input wire logic              rd_sel_n,
  input wire logic              wr_sel_n,
  input wire logic              lane_low_write_enable_n,
  input wire logic              lane_high_write_enable_n,
  input wire logic [DATA_W-1:0] q,
  input wire logic              q_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence rd_issue;
    !rd_sel_n && k_run;
  endsequence

  sequence rd_beats;
    q_oe [*4];
  endsequence

  rd_latency_a: assert property (rd_issue |-> ##6 rd_beats)
    else $error("read beats late or missing");
  rd_slot_a: assert property (!rd_sel_n |-> k_true)
    else $error("read strobe outside a true slot");
  wr_slot_a: assert property (!wr_sel_n |-> k_true)
    else $error("write strobe outside a true slot");
  rd_spacing_a: assert property (!rd_sel_n |=> rd_sel_n [*3])
    else $error("reads issued too close");
  wr_spacing_a: assert property (!wr_sel_n |=> wr_sel_n [*3])
    else $error("writes issued too close");
  idle_hiz_a: assert property (q_oe |-> !$past(rd_sel_n, 6) || !$past(rd_sel_n, 7)
    || !$past(rd_sel_n, 8) || !$past(rd_sel_n, 9))
    else $error("read data driven without a read");
  lane_window_a: assert property ((!lane_low_write_enable_n || !lane_high_write_enable_n)
    |-> !$past(wr_sel_n, 2) || !$past(wr_sel_n, 3) || !$past(wr_sel_n, 4) || !$past(wr_sel_n, 5))
    else $error("lane enables outside a write burst");
  stop_quiet_a: assert property (!k_run |-> rd_sel_n && wr_sel_n && !q_oe)
    else $error("clocks stopped with a burst in flight");
  stop_freeze_a: assert property (!k_run && !$past(k_run) |-> $stable(q) && $stable(q_oe))
    else $error("outputs moved while clocks stopped");
  slot_toggle_a: assert property (k_run && $past(k_run) && $past(rst_n)
    |-> k_true != $past(k_true))
    else $error("true clock slot did not alternate");
endmodule

/* verification/tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %0h want %0h", $time, (a), (e)); end end
// ==========================================================================
// Bench of both link ends, plus a lone device driven out of protocol.
// ==========================================================================
module tb
  import qbs_pkg::*;
;
  localparam int AWS = 8;
  localparam logic [AWS-1:0] BASE [4] = '{8'h10, 8'h24, 8'h37, 8'hfe};
  logic                 clock = 1'b0;
  logic                 rst_n, cmd_valid, cmd_write, cmd_accept, wd_valid, wd_ready;
  logic                 rd_valid, stop_req, clocks_stopped, read_busy, write_busy, wr_busy2;
  logic [AWS-1:0]       cmd_addr;
  logic [DATA_W-1:0]    wd_data, rd_data;
  logic [LANES-1:0]     wd_lanes_n;
  logic [DATA_W-1:0]    mem [2**AWS];
  logic [DATA_W-1:0]    wq_d [$];
  logic [LANES-1:0]     wq_l [$];
  int                   errors = 0, n_compared = 0, cyc = 0;

  qbs_link_if #(.AW(AWS)) link ();
  qbs_link_if #(.AW(AWS)) link2 ();
  qbs_sram_dev #(.AW(AWS)) qbs_sram_dev_i (.clock(clock), .rst_n(rst_n), .ce(1'b1),
    .link(link), .read_busy(read_busy), .write_busy(write_busy));
  qbs_sram_dev #(.AW(AWS)) qbs_sram_dev_i2 (.clock(clock), .rst_n(rst_n), .ce(1'b1),
    .link(link2), .read_busy(), .write_busy(wr_busy2));
  qbs_sram_ctl #(.AW(AWS)) qbs_sram_ctl_i (.clock(clock), .rst_n(rst_n), .ce(1'b1),
    .link(link), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_accept(cmd_accept), .wd_valid(wd_valid), .wd_data(wd_data), .wd_lanes_n(wd_lanes_n),
    .wd_ready(wd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .stop_req(stop_req),
    .clocks_stopped(clocks_stopped));
  qbs_link_assertions chk_i (.clock(clock), .rst_n(rst_n), .k_run(link.k_run),
    .k_true(link.k_true), .rd_sel_n(link.rd_sel_n), .wr_sel_n(link.wr_sel_n),
    .lane_low_write_enable_n(link.lane_low_write_enable_n),
    .lane_high_write_enable_n(link.lane_high_write_enable_n), .q(link.q), .q_oe(link.q_oe));

  always #5 clock = ~clock;

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict;
    end
  end

  function automatic logic [DATA_W-1:0] pat(int w);
    return DATA_W'(32'h0000_2f1d * w + 32'h0000_1234);
  endfunction

  task automatic push(input logic [DATA_W-1:0] dat, input logic [LANES-1:0] ln);
    @(negedge clock);
    while (wd_ready !== 1'b1) @(negedge clock);
    wd_valid = 1'b1;
    wd_data = dat;
    wd_lanes_n = ln;
    wq_d.push_back(dat);
    wq_l.push_back(ln);
    @(negedge clock);
    wd_valid = 1'b0;
  endtask

  // A write command pops its four beats into the reference memory.
  task automatic cmd(input logic w, input logic [AWS-1:0] a);
    int n;
    logic [AWS-1:0] ix;
    logic [DATA_W-1:0] dd;
    logic [LANES-1:0] ll;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (cmd_accept !== 1'b1 && n < 20);
    cmd_valid = 1'b0;
    `CHK(cmd_accept, 1'b1);
    for (int i = 0; w && i < 4; i++) begin
      ix = a + AWS'(i);
      dd = wq_d.pop_front();
      ll = wq_l.pop_front();
      if (!ll[0]) mem[ix][8:0] = dd[8:0];
      if (!ll[1]) mem[ix][17:9] = dd[17:9];
    end
    if (w) begin
      repeat (2) @(negedge clock);
      `CHK(write_busy, 1'b1);
    end
  endtask

  task automatic rd(input logic [AWS-1:0] a);
    int b, n;
    logic [AWS-1:0] ix;
    cmd(1'b0, a);
    b = 0;
    n = 0;
    while (b < 4 && n < 20) begin
      @(negedge clock);
      n++;
      if (rd_valid === 1'b1) begin
        ix = a + AWS'(b);
        `CHK(rd_data, mem[ix]);
        `CHK(read_busy, (b < 3));
        b++;
      end
    end
    `CHK(b, 4);
  endtask

  initial begin
    int n, oe_cnt, wb_seen;
    rst_n = 1'b0;
    {cmd_valid, cmd_write, wd_valid, stop_req} = 4'h0;
    cmd_addr = '0;
    wd_data = '0;
    wd_lanes_n = 2'h3;
    link2.k_run = 1'b0;
    link2.k_true = 1'b0;
    link2.rd_sel_n = 1'b1;
    link2.wr_sel_n = 1'b1;
    link2.addr = '0;
    link2.d = '0;
    link2.lane_low_write_enable_n = 1'b1;
    link2.lane_high_write_enable_n = 1'b1;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    // Four full bursts, then four with a different lane choice on every beat.
    for (int w = 0; w < 32; w++) push(pat(w), (w < 16) ? 2'h0 : {w[0], w[1]});
    `CHK(wd_ready, 1'b0);
    for (int k = 0; k < 8; k++) cmd(1'b1, BASE[k % 4]);
    repeat (12) @(negedge clock);
    `CHK(wd_ready, 1'b1);
    for (int k = 0; k < 4; k++) rd(BASE[k]);
    for (int w = 32; w < 36; w++) push(pat(w), 2'h0);
    cmd(1'b1, 8'h50);
    rd(8'h10);
    rd(8'h50);
    stop_req = 1'b1;
    n = 0;
    while (clocks_stopped !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    `CHK(link.k_run, 1'b0);
    `CHK(clocks_stopped, 1'b1);
    repeat (5) @(negedge clock);
    `CHK(link.q_oe, 1'b0);
    stop_req = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(clocks_stopped, 1'b0);
    rd(BASE[1]);
    // Both strobes low after idle, a read on the adjacent true edge, then a legal read.
    oe_cnt = 0;
    wb_seen = 0;
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      if (link2.q_oe === 1'b1) oe_cnt++;
      if (wr_busy2 === 1'b1) wb_seen++;
      link2.k_run = 1'b1;
      link2.k_true = ~link2.k_true;
      link2.rd_sel_n = !(i == 0 || i == 2 || i == 4);
      link2.wr_sel_n = !(i == 0);
    end
    @(negedge clock);
    link2.k_run = 1'b0;
    `CHK(oe_cnt, 8);
    `CHK(wb_seen, 0);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK(rd_valid, 1'b0);
    `CHK(link.rd_sel_n, 1'b1);
    give_verdict;
  end
endmodule
